// >>> design/sabd_pkg.sv
// Overview of operation
// RL1: status register is read only to software
// RL2: failed attempt sets only the matching cause bit
// RL3: start bit clears failure bits 8 to 0
// RL4: failure bit set raises interrupt when enabled
// RL5: first char bits 7:0, second 15:8
// RL6: raw bits of current character stay readable
// RL7: count 3.9 MHz ticks while line low
// RL8: eight threshold and eight divider registers
// RL9: upper limit of a rate is next lower
// RL10: matching divider value loads into serial port
// RL11: threshold holds 11 bits, top five unused
// RL12: divider value holds full 16 bits
// RL13: latest start bit tick count is readable
// RL14: status bit 6 high during an attempt
// RL15: status bit 5 cleared at start, set success
// RL16: status 4:3 parity none, even or odd
// RL17: status bit 2 word length seven or eight
// RL18: status bit 1 set on t, T or slash
// RL19: status bit 0 set on a or A
// RL20: fail bits 0 to 3 short/overflow/match/stop
// RL21: fail bits 4 to 8 second char, case, format
// RL22: on success program port, enable it, disarm
// RL23: control enable, irq enable, flag, loopback off
// RL24: terminal sends a/A repeated, then t/T/slash
// RL25: formats 7N2, 7E1, 7O1 and 8N1 only
// RL26: below lowest threshold short, tick at 11-bit full count overflow (count holds)
package sabd_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned MEAS_KHZ = 3900;
	localparam logic [8:0] TICK_INC = 9'(MEAS_KHZ / 100);
	localparam logic [8:0] TICK_MOD = 9'(CLK_KHZ / 100);
	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_FAIL = 8'h08;
	localparam logic [7:0] ADR_CHARS = 8'h0c;
	localparam logic [7:0] ADR_TEMP = 8'h10;
	localparam logic [7:0] ADR_COUNT = 8'h14;
	localparam logic [7:0] ADR_THR_BASE = 8'h20;
	localparam logic [7:0] ADR_DIV_BASE = 8'h40;
	localparam logic [7:0] ADR_TBL_MSK = 8'he0;
	localparam int TBL_IDX_LSB = 2;
	localparam int NUM_RATES = 8;
	localparam int CNT_W = 11;
	localparam int DIV_W = 16;
	localparam int BCLK_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 11'h7ff;
	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int CTL_EN = 0;
	localparam int CTL_IE = 1;
	localparam int CTL_FLAG = 2;
	localparam int CTL_LB = 4;
	localparam logic [15:0] CTL_MASK = 16'h0017;
	localparam int ST_FIRST = 0;
	localparam int ST_SECOND = 1;
	localparam int ST_WLEN = 2;
	localparam int ST_PAR = 3;
	localparam int ST_CORRECT = 5;
	localparam int ST_ACTIVE = 6;
	localparam int F_SHORT = 0;
	localparam int F_OVF = 1;
	localparam int F_MATCH1 = 2;
	localparam int F_STOP1 = 3;
	localparam int F_START2 = 4;
	localparam int F_MATCH2 = 5;
	localparam int F_STOP2 = 6;
	localparam int F_CASE = 7;
	localparam int F_NOFMT = 8;
	localparam int FAIL_W = 9;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam int FM_8N1 = 0;
	localparam int FM_7N2 = 1;
	localparam int FM_7E = 2;
	localparam int FM_7O = 3;
	localparam logic [6:0] CH_LA = 7'h61;
	localparam logic [6:0] CH_UA = 7'h41;
	localparam logic [6:0] CH_LT = 7'h74;
	localparam logic [6:0] CH_UT = 7'h54;
	localparam logic [6:0] CH_SL = 7'h2f;
	localparam logic [3:0] LAST_BIT = 4'h8;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] divider;
		logic eight_bit;
		logic [1:0] parity;
		logic two_stop;
		logic load;
	} sabd_port_cfg_s;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_MEAS = 7'h02,
		S_BITS = 7'h04,
		S_EVAL = 7'h08,
		S_HUNT = 7'h10,
		S_SCHK = 7'h20,
		S_DONE = 7'h40
	} sabd_state_e;
endpackage

// >>> design/sabd_detector.sv
`timescale 1ns/1ps
module sabd_detector (
	input wire logic clk_i, // 40 MHz
	input wire logic rst_i, // sync, high
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic wb_we_i, // write
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // ack
	input wire logic serial_rx_line_i, // serial receive line
	output sabd_pkg::sabd_port_cfg_s port_cfg_o, // port setup
	output logic port_enable_o, // serial port enable
	output logic loopback_off_o, // loopback disable pulse
	output logic cfg_lock_o, // port config locked
	output logic fail_irq_o // failure interrupt
);
	import sabd_pkg::*;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sabd_state_e state_reg, state_next;
	logic [15:0] ctrl_reg, status_reg, chars_reg;
	logic [FAIL_W-1:0] fail_reg, fail_vec;
	logic [8:0] shift_reg, acc_reg, acc_sum;
	logic [CNT_W-1:0] count_reg;
	logic [BCLK_W-1:0] bclk_reg, timer_reg;
	logic [3:0] bit_idx_reg;
	logic [3:0] cand_reg, char_mask;
	logic [2:0] rate_idx, rate_idx_reg;
	logic [CNT_W-1:0] thr_reg [NUM_RATES];
	logic [DIV_W-1:0] div_reg [NUM_RATES];
	logic [NUM_RATES-1:0] ge;
	logic rx_prev_reg, second_reg, lower_a_reg;
	logic start_det, tick, rise, short_bit, ovf, timer_zero, sample;
	logic is_a, is_t, stop_ok, mixed, wr, ack_reg;
	logic [15:0] wmask, rd_data;
	logic [6:0] c7;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	// write lands at the edge where the master sees ack
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
			wb_dat_o <= {16'h0, rd_data};
		end
	end
	assign wb_ack_o = ack_reg;

	always_comb begin
		rd_data = 16'h0;
		case (wb_adr_i & ~8'h03)
			ADR_CTRL: rd_data = ctrl_reg;
			ADR_STATUS: rd_data = status_reg; // RL1
			ADR_FAIL: rd_data = {7'h0, fail_reg};
			ADR_CHARS: rd_data = chars_reg;
			ADR_TEMP: rd_data = {7'h0, shift_reg}; // RL6
			ADR_COUNT: rd_data = {5'h0, count_reg}; // RL13
			default: begin
				if ((wb_adr_i & ADR_TBL_MSK) == ADR_THR_BASE) begin
					rd_data = {5'h0,
						thr_reg[wb_adr_i[TBL_IDX_LSB +: 3]]};
				end else if ((wb_adr_i & ADR_TBL_MSK) == ADR_DIV_BASE) begin
					rd_data = div_reg[wb_adr_i[TBL_IDX_LSB +: 3]];
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// rate tables
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_RATES; i++) begin : g_rate
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				thr_reg[i] <= '0;
				div_reg[i] <= '0;
			end else if (wr && wb_adr_i[TBL_IDX_LSB +: 3] == 3'(i)) begin
				if ((wb_adr_i & ADR_TBL_MSK) == ADR_THR_BASE) begin
					thr_reg[i] <= (thr_reg[i] & ~wmask[CNT_W-1:0]) |
						(wb_dat_i[CNT_W-1:0] & wmask[CNT_W-1:0]); // RL11
				end
				if ((wb_adr_i & ADR_TBL_MSK) == ADR_DIV_BASE) begin
					div_reg[i] <= (div_reg[i] & ~wmask) |
						(wb_dat_i[15:0] & wmask); // RL12
				end
			end
		end
		assign ge[i] = count_reg >= thr_reg[i]; // RL8
	end

	// highest threshold reached picks the rate
	always_comb begin
		rate_idx = 3'h0;
		for (int k = 0; k < NUM_RATES; k++) begin
			if (ge[k]) begin
				rate_idx = 3'(k); // RL9
			end
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= 16'h0;
		end else begin
			if (wr && (wb_adr_i & ~8'h03) == ADR_CTRL) begin
				ctrl_reg <= (ctrl_reg & ~wmask) |
					(wb_dat_i[15:0] & wmask & CTL_MASK);
			end
			if (state_reg == S_DONE) begin
				ctrl_reg[CTL_EN] <= 1'b0; // RL22
				ctrl_reg[CTL_FLAG] <= 1'b1; // RL23
			end
		end
	end

	// ----------------------------------------------------------------
	// measurement tick and line sampling
	// ----------------------------------------------------------------
	assign acc_sum = acc_reg + TICK_INC;
	assign tick = acc_sum >= TICK_MOD;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= 9'h0;
			rx_prev_reg <= 1'b1;
		end else begin
			acc_reg <= tick ? acc_sum - TICK_MOD : acc_sum;
			rx_prev_reg <= serial_rx_line_i;
		end
	end

	assign start_det = state_reg == S_IDLE && ctrl_reg[CTL_EN] &&
		rx_prev_reg && !serial_rx_line_i;
	assign rise = state_reg == S_MEAS && serial_rx_line_i;
	assign short_bit = count_reg < thr_reg[0]; // RL26
	assign ovf = state_reg == S_MEAS && tick && count_reg == CNT_MAX;
	assign timer_zero = timer_reg == '0;
	assign sample = state_reg == S_BITS && timer_zero;

	// ----------------------------------------------------------------
	// character checks
	// ----------------------------------------------------------------
	assign c7 = shift_reg[6:0];
	assign is_a = c7 == CH_LA || c7 == CH_UA; // RL24
	assign is_t = c7 == CH_LT || c7 == CH_UT || c7 == CH_SL;
	assign stop_ok = shift_reg[LAST_BIT];
	assign mixed = (lower_a_reg && c7 == CH_UT) ||
		(!lower_a_reg && c7 == CH_LT);

	// formats consistent with bit 7 of this character
	always_comb begin
		char_mask = 4'h0;
		char_mask[FM_8N1] = !shift_reg[7]; // RL25
		char_mask[FM_7N2] = shift_reg[7];
		char_mask[FM_7E] = shift_reg[7] == ^c7;
		char_mask[FM_7O] = shift_reg[7] != ^c7;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		fail_vec = '0;
		case (state_reg)
			S_IDLE: begin
				if (start_det) begin
					state_next = S_MEAS;
				end
			end
			S_MEAS: begin
				if (rise) begin
					if (short_bit) begin
						fail_vec[F_SHORT] = 1'b1; // RL20
					end else begin
						state_next = S_BITS;
					end
				end else if (ovf) begin
					fail_vec[F_OVF] = 1'b1; // RL26
				end
			end
			S_BITS: begin
				if (sample && bit_idx_reg == LAST_BIT) begin
					state_next = S_EVAL;
				end
			end
			S_EVAL: begin
				if (!second_reg) begin
					if (!is_a) begin
						fail_vec[F_MATCH1] = 1'b1; // RL20
					end else if (!stop_ok) begin
						fail_vec[F_STOP1] = 1'b1; // RL20
					end else begin
						state_next = S_HUNT;
					end
				end else if (!(is_a || is_t)) begin
					fail_vec[F_MATCH2] = 1'b1; // RL21
				end else if (!stop_ok) begin
					fail_vec[F_STOP2] = 1'b1; // RL21
				end else if (is_a) begin
					state_next = S_HUNT;
				end else if (mixed) begin
					fail_vec[F_CASE] = 1'b1; // RL21
				end else if ((cand_reg & char_mask) == 4'h0) begin
					fail_vec[F_NOFMT] = 1'b1; // RL21
				end else begin
					state_next = S_DONE;
				end
			end
			S_HUNT: begin
				if (!serial_rx_line_i) begin
					state_next = S_SCHK;
				end
			end
			S_SCHK: begin
				if (timer_zero) begin
					if (serial_rx_line_i) begin
						fail_vec[F_START2] = 1'b1; // RL21
					end else begin
						state_next = S_BITS;
					end
				end
			end
			S_DONE: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
		if (state_reg != S_IDLE && !ctrl_reg[CTL_EN]) begin
			state_next = S_IDLE;
		end
		if (fail_vec != '0) begin
			state_next = S_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// start bit measurement
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= '0;
			bclk_reg <= '0;
			rate_idx_reg <= 3'h0;
		end else if (start_det) begin
			count_reg <= '0;
			bclk_reg <= 16'h1;
		end else if (state_reg == S_MEAS) begin
			if (tick && count_reg != CNT_MAX) begin
				count_reg <= count_reg + 11'h1; // RL7
			end
			if (bclk_reg != '1) begin
				bclk_reg <= bclk_reg + 16'h1;
			end
			rate_idx_reg <= rate_idx;
		end
	end

	// ----------------------------------------------------------------
	// bit timer and shifter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_reg <= '0;
			bit_idx_reg <= 4'h0;
			shift_reg <= 9'h0;
		end else begin
			if ((rise && !short_bit) ||
					(state_reg == S_HUNT && !serial_rx_line_i)) begin
				timer_reg <= bclk_reg >> 1;
			end else if (sample ||
					(state_reg == S_SCHK && timer_zero)) begin
				timer_reg <= bclk_reg;
			end else if (!timer_zero) begin
				timer_reg <= timer_reg - 16'h1;
			end
			if (state_next == S_BITS && state_reg != S_BITS) begin
				bit_idx_reg <= 4'h0;
			end else if (sample) begin
				bit_idx_reg <= bit_idx_reg + 4'h1;
			end
			if (sample) begin
				shift_reg <= {serial_rx_line_i, shift_reg[8:1]}; // RL6
			end
		end
	end

	// ----------------------------------------------------------------
	// character record and format candidates
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chars_reg <= 16'h0;
			second_reg <= 1'b0;
			lower_a_reg <= 1'b0;
			cand_reg <= 4'hf;
		end else if (start_det) begin
			chars_reg <= 16'h0;
			second_reg <= 1'b0;
			cand_reg <= 4'hf;
		end else if (state_reg == S_EVAL) begin
			if (is_a) begin
				chars_reg[7:0] <= {1'b0, c7}; // RL5
				lower_a_reg <= c7 == CH_LA;
				second_reg <= 1'b1;
			end else if (second_reg && is_t) begin
				chars_reg[15:8] <= {1'b0, c7}; // RL5
			end
			cand_reg <= cand_reg & char_mask;
		end
	end

	// ----------------------------------------------------------------
	// status and failure registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= 16'h0;
		end else if (start_det) begin
			status_reg[ST_ACTIVE] <= 1'b1; // RL14
			status_reg[ST_CORRECT] <= 1'b0; // RL15
			status_reg[ST_SECOND] <= 1'b0; // RL18
			status_reg[ST_FIRST] <= 1'b0; // RL19
		end else begin
			if (state_reg == S_EVAL && is_a && !second_reg) begin
				status_reg[ST_FIRST] <= 1'b1; // RL19
			end
			if (state_reg == S_EVAL && is_t && second_reg) begin
				status_reg[ST_SECOND] <= 1'b1; // RL18
			end
			if (state_reg == S_DONE) begin
				status_reg[ST_CORRECT] <= 1'b1; // RL15
				status_reg[ST_WLEN] <= cand_reg[FM_8N1]; // RL17
				status_reg[ST_PAR +: 2] <= (cand_reg[FM_8N1] ||
					cand_reg[FM_7N2]) ? PAR_NONE :
					cand_reg[FM_7E] ? PAR_EVEN : PAR_ODD; // RL16
			end
			if (state_reg != S_IDLE && state_next == S_IDLE) begin
				status_reg[ST_ACTIVE] <= 1'b0; // RL14
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_reg <= '0;
		end else if (start_det) begin
			fail_reg <= '0; // RL3
		end else begin
			fail_reg <= fail_reg | fail_vec; // RL2
		end
	end

	// ----------------------------------------------------------------
	// serial port programming and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_cfg_o <= '0;
			port_enable_o <= 1'b0;
			loopback_off_o <= 1'b0;
			cfg_lock_o <= 1'b0;
			fail_irq_o <= 1'b0;
		end else begin
			port_cfg_o.load <= state_reg == S_DONE;
			loopback_off_o <= state_reg == S_DONE && ctrl_reg[CTL_LB];
			if (state_reg == S_DONE) begin
				port_cfg_o.divider <= div_reg[rate_idx_reg]; // RL10
				port_cfg_o.eight_bit <= cand_reg[FM_8N1];
				port_cfg_o.two_stop <= !cand_reg[FM_8N1] &&
					cand_reg[FM_7N2];
				port_cfg_o.parity <= (cand_reg[FM_8N1] ||
					cand_reg[FM_7N2]) ? PAR_NONE :
					cand_reg[FM_7E] ? PAR_EVEN : PAR_ODD;
				port_enable_o <= 1'b1; // RL22
			end else if (start_det) begin
				port_enable_o <= 1'b0;
			end
			cfg_lock_o <= state_next != S_IDLE; // RL22
			fail_irq_o <= ctrl_reg[CTL_IE] && fail_reg != '0; // RL4
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_STATUS_RO: assert property ( // RL1
		$changed(status_reg) |-> $past(state_reg) != S_IDLE ||
			$past(start_det))
		else $error("status changed outside an attempt");
	AST_FAIL_CLR: assert property (start_det |=> fail_reg == '0) // RL3
		else $error("failure bits not cleared at start");
	AST_FAIL_ONE: assert property ( // RL2
		fail_vec != '0 |=> $onehot(fail_reg) && state_reg == S_IDLE)
		else $error("failure not a single cause");
	AST_IRQ: assert property ( // RL4
		ctrl_reg[CTL_IE] && fail_reg != '0 |=> fail_irq_o)
		else $error("failure interrupt missing");
	AST_ACTIVE: assert property ( // RL14
		state_reg != S_IDLE |-> status_reg[ST_ACTIVE])
		else $error("active bit low during attempt");
	AST_DONE: assert property ( // RL15
		state_reg == S_DONE |=> status_reg[ST_CORRECT] &&
			!ctrl_reg[CTL_EN] && ctrl_reg[CTL_FLAG] && port_enable_o)
		else $error("success not reported");
	AST_LOAD: assert property ( // RL10
		state_reg == S_DONE |=> port_cfg_o.load ##1 !port_cfg_o.load)
		else $error("divider load not one pulse");
	AST_OVF: assert property (ovf && !rise |=> fail_reg[F_OVF]) // RL26
		else $error("overflow not flagged");
	AST_SHORT: assert property ( // RL26
		rise && short_bit |=> fail_reg[F_SHORT] && cfg_lock_o == 1'b0)
		else $error("short start bit not flagged");
	AST_ACK: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not one cycle");
	COV_SUCCESS: cover property (state_reg == S_DONE);
	COV_FAIL: cover property (fail_vec != '0 ##1 fail_irq_o);
	COV_REPEAT_A: cover property (
		state_reg == S_EVAL && second_reg && is_a);
endmodule

// >>> tb/sabd_term_model.sv
`timescale 1ns/1ps
// ----
// remote terminal sending framed characters
// ----
module sabd_term_model (
	input wire logic clk_i, // bench clock
	output logic serial_rx_line_o // line towards detector
);
	initial serial_rx_line_o = 1'b1;
	task automatic put_bit(input logic b, input int per);
		serial_rx_line_o <= b;
		repeat (per) @(posedge clk_i);
	endtask
	// fmt 0 8n1, 1 7n2, 2 7e1, 3 7o1
	task automatic send_char(input logic [6:0] ch, input int fmt,
		input int per, input logic stop_ok);
		logic [8:0] fr;
		fr[6:0] = ch;
		case (fmt)
			0: fr[7] = 1'b0;
			1: fr[7] = 1'b1;
			2: fr[7] = ^ch;
			default: fr[7] = ~^ch;
		endcase
		fr[8] = stop_ok;
		put_bit(1'b0, per);
		for (int i = 0; i < 9; i++) put_bit(fr[i], per);
		if (fmt == 1) put_bit(1'b1, per);
		put_bit(1'b1, per);
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ----
// bench for the rate detector
// ----
module tb_top;
	import sabd_pkg::*;
	typedef struct {
		logic [7:0] adr;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] m;
	} sabd_exp_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, rx_line, port_enable_o, loopback_off_o;
	logic cfg_lock_o, fail_irq_o;
	sabd_port_cfg_s port_cfg_o;
	sabd_exp_s rd_q[$];
	sabd_port_cfg_s cfg_q[$];
	int error_cnt = 0;
	int n_tests = 0;
	int lb_cnt = 0;
	logic [15:0] div_tbl[NUM_RATES];
	string str[4] = '{"aat", "a/", "at", "AT"};
	logic [15:0] chp[4] = '{16'h7461, 16'h2f61, 16'h7461, 16'h5441};
	logic [1:0] par[4] = '{PAR_NONE, PAR_NONE, PAR_EVEN, PAR_ODD};

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	sabd_detector dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.serial_rx_line_i(rx_line), .port_cfg_o(port_cfg_o),
		.port_enable_o(port_enable_o), .loopback_off_o(loopback_off_o),
		.cfg_lock_o(cfg_lock_o), .fail_irq_o(fail_irq_o));
	sabd_term_model term_u (.clk_i(clk_i), .serial_rx_line_o(rx_line));

	// ----
	// compare, bus and run control
	// ----
	task automatic check(input string what, input logic [31:0] got,
		input logic [31:0] lo, input logic [31:0] hi);
		n_tests++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			error_cnt++;
			$display("ERROR %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	task automatic check_cfg(input sabd_port_cfg_s e);
		n_tests++;
		if ((port_cfg_o >> 1) !== (e >> 1)) begin
			error_cnt++;
			$display("ERROR port cfg expected %h seen %h", e, port_cfg_o);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wb_cycle(input logic [7:0] adr, input logic we,
		input logic [31:0] dat);
		int n;
		n = 0;
		wb_adr_i <= adr;
		wb_we_i <= we;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd_exp(input logic [7:0] adr, input logic [31:0] lo,
		input logic [31:0] hi, input logic [31:0] m);
		rd_q.push_back('{adr, lo, hi, m});
		wb_cycle(adr, 1'b0, 32'h0);
	endtask
	// empty string sends a lone short low pulse
	task automatic attempt(input string s, input int fmt, input int per,
		input logic stop_ok, input logic [31:0] ctl);
		byte c;
		wb_cycle(ADR_CTRL, 1'b1, ctl);
		if (s.len() == 0) begin
			term_u.put_bit(1'b0, 20);
			term_u.put_bit(1'b1, 100);
		end
		for (int i = 0; i < s.len(); i++) begin
			c = s[i];
			term_u.send_char(c[6:0], fmt, per, stop_ok);
		end
		repeat (20) @(posedge clk_i);
	endtask
	task automatic fail_case(input string s, input logic stop_ok,
		input logic [31:0] ctl, input logic [31:0] f, input logic [31:0] t);
		attempt(s, 0, 164, stop_ok, ctl);
		rd_exp(ADR_FAIL, f, f, 32'hffff);
		rd_exp(ADR_TEMP, t, t, 32'h1ff);
		check("irq", {31'h0, fail_irq_o}, {31'h0, ctl[1]},
			{31'h0, ctl[1]});
		$display("failure case '%s' done", s);
	endtask

	always @(posedge clk_i) begin
		sabd_exp_s e;
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
			e = rd_q.pop_front();
			check($sformatf("reg %h", e.adr), wb_dat_o & e.m, e.lo, e.hi);
		end
		if (port_cfg_o.load === 1'b1) begin
			if (cfg_q.size() == 0)
				check("spare load", 32'h1, 32'h0, 32'h0);
			else
				check_cfg(cfg_q.pop_front());
		end
		if (loopback_off_o === 1'b1) lb_cnt++;
	end

	initial begin
		#2500000;
		error_cnt++;
		end_sim();
	end

	initial begin
		int sd;
		int k;
		int per;
		logic [31:0] ctl;
		logic [31:0] st;
		sd = $urandom(32'he154);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_exp(ADR_CTRL, 0, 0, 32'hffff);
		rd_exp(ADR_THR_BASE, 0, 0, 32'hffff);
		rd_exp(8'hfc, 0, 0, 32'hffffffff);
		for (int i = 0; i < NUM_RATES; i++) begin
			div_tbl[i] = 16'($urandom());
			wb_cycle(ADR_THR_BASE + 8'(4 * i), 1'b1, 32'hf800 | (8 * i + 4));
			wb_cycle(ADR_DIV_BASE + 8'(4 * i), 1'b1, {16'h0, div_tbl[i]});
			rd_exp(ADR_THR_BASE + 8'(4 * i), 8 * i + 4, 8 * i + 4, '1);
			rd_exp(ADR_DIV_BASE + 8'(4 * i), div_tbl[i], div_tbl[i], '1);
		end
		$display("register table test done");
		fail_case("", 1'b1, 32'h3, 32'h001, 32'h0);
		fail_case("e", 1'b1, 32'h3, 32'h004, 32'h165);
		fail_case("a", 1'b0, 32'h3, 32'h008, 32'h061);
		fail_case("aT", 1'b1, 32'h3, 32'h080, 32'h154);
		fail_case("ax", 1'b1, 32'h1, 32'h020, 32'h178);
		// second character faults: lost start bit, bad stop, no format
		wb_cycle(ADR_CTRL, 1'b1, 32'h3);
		term_u.send_char(CH_LA, 0, 164, 1'b1);
		term_u.put_bit(1'b0, 20);
		term_u.put_bit(1'b1, 300);
		rd_exp(ADR_FAIL, 32'h010, 32'h010, 32'h1ff);
		term_u.send_char(CH_LA, 0, 164, 1'b1);
		term_u.send_char(CH_LT, 0, 164, 1'b0);
		term_u.put_bit(1'b1, 20);
		rd_exp(ADR_FAIL, 32'h040, 32'h040, 32'h1ff);
		term_u.send_char(CH_LA, 0, 164, 1'b1);
		term_u.send_char(CH_LA, 1, 164, 1'b1);
		term_u.send_char(CH_LT, 0, 164, 1'b1);
		term_u.put_bit(1'b1, 20);
		rd_exp(ADR_FAIL, 32'h100, 32'h100, 32'h1ff);
		$display("second character fault test done");
		for (int f = 0; f < 4; f++) begin
			k = 2 * f + 1;
			per = 82 * (k + 1);
			ctl = (f == 0) ? 32'h13 : 32'h3;
			cfg_q.push_back('{div_tbl[k], f == 0, par[f], f == 1, 1'b1});
			fork
				attempt(str[f], f, per, 1'b1, ctl);
				begin
					repeat (2 * per) @(posedge clk_i);
					rd_exp(ADR_STATUS, 32'h40, 32'h40, 32'h63);
					check("lock", {31'h0, cfg_lock_o}, 1, 1);
					check("port en", {31'h0, port_enable_o}, 0, 0);
				end
			join
			wb_cycle(ADR_STATUS, 1'b1, 32'hffff);
			st = 32'h23 | (32'(par[f]) << 3) | (f == 0 ? 32'h4 : 32'h0);
			rd_exp(ADR_STATUS, st, st, 32'h7f);
			rd_exp(ADR_FAIL, 0, 0, 32'h1ff);
			rd_exp(ADR_CHARS, chp[f], chp[f], 32'hffff);
			rd_exp(ADR_COUNT, 8 * (k + 1) - 2, 8 * (k + 1) + 1, '1);
			rd_exp(ADR_CTRL, (ctl & 32'hfe) | 4, (ctl & 32'hfe) | 4, '1);
			check("port en", {31'h0, port_enable_o}, 1, 1);
			check("lock", {31'h0, cfg_lock_o}, 0, 0);
			$display("detection test %0d done", f);
		end
		wb_cycle(ADR_CTRL, 1'b1, 32'h0);
		rd_exp(ADR_CTRL, 0, 0, 32'hffff);
		check("loopback pulses", lb_cnt, 1, 1);
		check("loads left", cfg_q.size(), 0, 0);
		end_sim();
	end
endmodule
